// [src/arr_pkg.sv]
/*
 * Constants shared by the result readout port and its formatter.
 * Assumes the converter clock is clk_sys_in at 100 MHz.
 */
package arr_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [1:0] ADDR_CTRL = 2'h0;
	localparam logic [1:0] ADDR_STAT = 2'h1;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam int CTRL_SUM_BIT = 0;
	localparam int CTRL_FLAG_BIT = 1;
	localparam int CTRL_SHOT_BIT = 2;
	localparam int STAT_READY_BIT = 0;
	localparam int STAT_CRM_BIT = 1;

	// ****************************************
	// Serial commands
	// ****************************************
	localparam logic [7:0] CMD_START_CRM = 8'h10;
	localparam logic [7:0] CMD_STOP_CRM = 8'h11;
	localparam logic [6:0] CMD_RDATA_HI = 7'h09;

	// ****************************************
	// Result format
	// ****************************************
	localparam logic [23:0] CODE_POS_FS = 24'h7fffff;
	localparam logic [23:0] CODE_NEG_FS = 24'h800000;
	localparam logic [7:0] SUM_OFFSET = 8'h9b;
	localparam logic [4:0] LAST_BIT_NOSUM = 5'h17;
	localparam logic [4:0] LAST_BIT_SUM = 5'h1f;
	localparam logic [4:0] WORD_TOP = 5'h1f;

	// ****************************************
	// Timing, in master-clock cycles
	// ****************************************
	localparam int UPDATE_CYC = 20;
	localparam logic [4:0] UPDATE_LAST = 5'(UPDATE_CYC - 1);

	typedef enum logic {
		ARR_IDLE,
		ARR_UPDATE
	} arr_win_t;

endpackage : arr_pkg

// [src/arr_result_format.sv]
/*
 * Result formatter: saturates, adds the check byte and range mark,
 * and holds the whole word in one register.
 * Assumes load_in is a one-cycle pulse on the same clock.
 */
`timescale 1ns/1ns
module arr_result_format
	import arr_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	// Raw result
	input  wire logic        load_in,
	input  wire logic [25:0] raw_in,
	input  wire logic        oor_in,
	// Options
	input  wire logic        sum_en_in,
	input  wire logic        flag_en_in,
	// Held word, data in [31:8]
	output logic      [31:0] word_out
);

	// ****************************************
	// Formatting
	// ****************************************
	wire logic        too_high;
	wire logic        too_low;
	wire logic [23:0] code;
	wire logic        oor;
	wire logic [23:0] data;
	wire logic [7:0]  sum;
	wire logic [7:0]  tail;

	assign too_high = ~raw_in[25] && (raw_in[24:23] != 2'h0);
	assign too_low  = raw_in[25] && (raw_in[24:23] != 2'h3);
	assign code = too_high ? CODE_POS_FS :
		too_low ? CODE_NEG_FS : raw_in[23:0];
	assign oor = oor_in | too_high | too_low;

	assign data = (flag_en_in && !sum_en_in) ?
		{code[23:1], oor} : code;

	assign sum = data[23:16] + data[15:8] + data[7:0] + SUM_OFFSET;

	assign tail = flag_en_in ? {oor, sum[6:0]} : sum;

	// ****************************************
	// Holding register
	// ****************************************
	// whole word at once
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			word_out <= 32'h0;
		end else if (load_in) begin
			word_out <= {data, tail};
		end
	end

endmodule : arr_result_format

// [src/arr_readout.sv]
/*
 * Result readout port of a 24-bit converter: ready output, status
 * mirror, result formatting and serial shift-out.
 * Assumes clk_sys_in is the converter master clock; the serial pins
 * come from a host in another clock domain and are synchronised.
 */
// Decided for this implementation: the address map and the strobed register port.
//
// Summary of operation
// - Ready pin low, mirrored in status
// - Status bit follows pin outside continuous read
// - Ready high from reset until result
// - Gate mode: first falling edge clears ready
// - Unread: ready pulses high over update
// - 24-bit two's complement, MSB first
// - Overrange saturates at full-scale codes
// - Checksum enable adds fourth byte
// - Checksum is byte sum plus 9Bh
// - Checksum only on result reads
// - Both options: mark in checksum bit 7
// - Mark only: replaces result bit 0
// - Extra clocks repeat the same result
// - Continuous mode shifts on rising edges
// - Continuous read: output follows ready until first rise
// - Stop command may overlap result bits
// - Opcode 11h leaves continuous read
// - Continuous read at reset, 10h re-enters
// - Single-shot bit picks pulse mode
`timescale 1ns/1ns
module arr_readout
	import arr_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	// Converter side
	input  wire logic        conv_valid_in,
	input  wire logic [25:0] conv_raw_in,
	input  wire logic        conv_oor_in,
	input  wire logic        conv_start_in,
	// Register port
	input  wire logic [1:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [7:0]  reg_rdata_out,
	// Serial link
	input  wire logic        sclk_in,
	input  wire logic        cs_n_in,
	input  wire logic        din_in,
	output logic             dout_out,
	output logic             dout_oe_n_out,
	// Ready pin
	output logic             result_ready_n_out
);

	// ****************************************
	// Synchronisers
	// ****************************************
	logic sclk_s1_reg;
	logic sclk_s2_reg;
	logic sclk_s3_reg;
	logic cs_n_s1_reg;
	logic cs_n_s2_reg;
	logic din_s1_reg;
	logic din_s2_reg;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sclk_s1_reg <= 1'b0;
			sclk_s2_reg <= 1'b0;
			sclk_s3_reg <= 1'b0;
			cs_n_s1_reg <= 1'b1;
			cs_n_s2_reg <= 1'b1;
			din_s1_reg  <= 1'b0;
			din_s2_reg  <= 1'b0;
		end else begin
			sclk_s1_reg <= sclk_in;
			sclk_s2_reg <= sclk_s1_reg;
			sclk_s3_reg <= sclk_s2_reg;
			cs_n_s1_reg <= cs_n_in;
			cs_n_s2_reg <= cs_n_s1_reg;
			din_s1_reg  <= din_in;
			din_s2_reg  <= din_s1_reg;
		end
	end

	wire logic sclk_rise;
	wire logic sclk_fall;
	wire logic cs_act;

	assign cs_act    = ~cs_n_s2_reg;
	assign sclk_rise = cs_act & sclk_s2_reg & ~sclk_s3_reg;
	assign sclk_fall = cs_act & ~sclk_s2_reg & sclk_s3_reg;

	// ****************************************
	// Control register
	// ****************************************
	logic [2:0] ctrl_reg;
	logic [7:0] rdata_reg;

	wire logic sum_en;
	wire logic flag_en;
	wire logic single_shot;

	assign sum_en      = ctrl_reg[CTRL_SUM_BIT];
	assign flag_en     = ctrl_reg[CTRL_FLAG_BIT];
	assign single_shot = ctrl_reg[CTRL_SHOT_BIT];

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_reg <= CTRL_RESET;
		end else if (reg_wr_in && reg_addr_in == ADDR_CTRL) begin
			ctrl_reg <= reg_wdata_in[2:0];
		end
	end

	// ****************************************
	// Command byte capture
	// ****************************************
	// Bits are taken on falling edges; the count restarts whenever
	// chip select goes high, which realigns a confused host.
	logic [6:0] cmd_sh_reg;
	logic [2:0] cmd_cnt_reg;
	logic       crm_reg;
	logic       armed_reg;

	wire logic       byte_done;
	wire logic [7:0] cmd_byte;
	wire logic       is_stop;
	wire logic       is_start_crm;
	wire logic       is_rdata;

	assign byte_done    = sclk_fall && cmd_cnt_reg == 3'h7;
	assign cmd_byte     = {cmd_sh_reg, din_s2_reg};
	assign is_stop      = byte_done && cmd_byte == CMD_STOP_CRM;
	assign is_start_crm = byte_done && cmd_byte == CMD_START_CRM;
	assign is_rdata     = byte_done && !crm_reg &&
		cmd_byte[7:1] == CMD_RDATA_HI;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_sh_reg  <= 7'h0;
			cmd_cnt_reg <= 3'h0;
		end else if (!cs_act) begin
			cmd_cnt_reg <= 3'h0;
		end else if (sclk_fall) begin
			cmd_sh_reg  <= {cmd_sh_reg[5:0], din_s2_reg};
			cmd_cnt_reg <= cmd_cnt_reg + 3'h1;
		end
	end

	// ****************************************
	// Read mode
	// ****************************************
	wire logic crm_next;
	wire logic armed_next;

	assign crm_next = is_stop ? 1'b0 :
		is_start_crm ? 1'b1 : crm_reg;

	assign armed_next = (!cs_act || crm_next) ? 1'b0 :
		is_rdata ? 1'b1 : armed_reg;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			crm_reg   <= 1'b1;
			armed_reg <= 1'b0;
		end else begin
			crm_reg   <= crm_next;
			armed_reg <= armed_next;
		end
	end

	// ****************************************
	// Update window and ready
	// ****************************************
	arr_win_t   win_reg;
	arr_win_t   win_next;
	logic [4:0] win_cnt_reg;
	logic [4:0] win_cnt_next;
	logic       ready_n_reg;
	logic       ready_n_next;
	logic       rd_act_reg;

	wire logic win_done;
	wire logic read_clear;
	wire logic new_conv;

	assign win_done = win_reg == ARR_UPDATE && win_cnt_reg == 5'h0;

	assign read_clear = !single_shot && rd_act_reg && sclk_fall;

	assign new_conv = single_shot && conv_start_in;

	always_comb begin
		win_next     = win_reg;
		win_cnt_next = win_cnt_reg;
		ready_n_next = ready_n_reg;
		unique case (win_reg)
			ARR_IDLE: begin
				if (conv_valid_in) begin
					win_next     = ARR_UPDATE;
					win_cnt_next = UPDATE_LAST;
					ready_n_next = 1'b1;
				end else if (read_clear || new_conv) begin
					ready_n_next = 1'b1;
				end
			end
			ARR_UPDATE: begin
				if (win_done) begin
					win_next     = ARR_IDLE;
					ready_n_next = 1'b0;
				end else begin
					win_cnt_next = win_cnt_reg - 5'h1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			win_reg     <= ARR_IDLE;
			win_cnt_reg <= 5'h0;
			ready_n_reg <= 1'b1;
		end else begin
			win_reg     <= win_next;
			win_cnt_reg <= win_cnt_next;
			ready_n_reg <= ready_n_next;
		end
	end

	assign result_ready_n_out = ready_n_reg;

	// ****************************************
	// Result formatter
	// ****************************************
	wire logic [31:0] word;

	arr_result_format u_format (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.load_in    (conv_valid_in && win_reg == ARR_IDLE),
		.raw_in     (conv_raw_in),
		.oor_in     (conv_oor_in),
		.sum_en_in  (sum_en),
		.flag_en_in (flag_en),
		.word_out   (word)
	);

	// ****************************************
	// Shift-out
	// ****************************************
	// Reads are not guarded against the update window; a host that
	// reads inside it gets a mixed word, as the timing forbids it.
	logic [4:0] idx_reg;
	logic       dout_reg;

	wire logic       shift_ok;
	wire logic       shift;
	wire logic [4:0] last_bit;
	wire logic       out_bit;
	wire logic [4:0] idx_next;

	assign shift_ok = crm_reg || armed_reg;
	assign shift    = sclk_rise && shift_ok;

	assign last_bit = sum_en ? LAST_BIT_SUM : LAST_BIT_NOSUM;

	assign out_bit  = word[WORD_TOP - idx_reg];

	assign idx_next = (idx_reg == last_bit) ? 5'h0 :
		idx_reg + 5'h1;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_act_reg <= 1'b0;
			idx_reg    <= 5'h0;
		end else if (!cs_act || win_done || !shift_ok) begin
			rd_act_reg <= 1'b0;
			idx_reg    <= 5'h0;
		end else if (shift) begin
			rd_act_reg <= 1'b1;
			idx_reg    <= idx_next;
		end
	end

	wire logic dout_next;

	assign dout_next = shift ? out_bit :
		(crm_reg && !rd_act_reg) ? ready_n_reg :
		(rd_act_reg ? dout_reg : 1'b0);

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dout_reg <= 1'b0;
		end else begin
			dout_reg <= dout_next;
		end
	end

	assign dout_out      = dout_reg;
	assign dout_oe_n_out = cs_n_s2_reg;

	// ****************************************
	// Register reads
	// ****************************************
	wire logic stat_ready;
	wire logic [7:0] rd_value;

	assign stat_ready = crm_reg ? 1'b1 : ready_n_reg;

	assign rd_value =
		(reg_addr_in == ADDR_CTRL) ? {5'h0, ctrl_reg} :
		(reg_addr_in == ADDR_STAT) ?
			{6'h0, crm_reg, stat_ready} : 8'h0;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_reg <= 8'h0;
		end else if (reg_rd_in) begin
			rdata_reg <= rd_value;
		end else begin
			rdata_reg <= 8'h0;
		end
	end

	assign reg_rdata_out = rdata_reg;

endmodule : arr_readout

// [test/arr_readout_assertions.sv]
/* Port checker for arr_readout.
 Assumes it is bound to every arr_readout instance. */
`timescale 1ns/1ns
module arr_readout_assertions
	import arr_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys_in,
	input wire logic       rst_n_in,
	// Converter and register port
	input wire logic       conv_valid_in,
	input wire logic       conv_start_in,
	input wire logic [1:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	// Serial and ready
	input wire logic       sclk_in,
	input wire logic       cs_n_in,
	input wire logic       dout_oe_n_out,
	input wire logic       result_ready_n_out
);
	// ****
	// Serial activity age, saturates so it never wraps
	// ****
	logic       sclk_d_reg;
	logic [3:0] quiet_reg;
	logic [3:0] quiet_next;
	assign quiet_next = (sclk_in != sclk_d_reg) ? 4'h0 :
		(quiet_reg == 4'hf) ? quiet_reg : quiet_reg + 4'h1;
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sclk_d_reg <= 1'b0;
			quiet_reg <= 4'hf;
		end else begin
			sclk_d_reg <= sclk_in;
			quiet_reg <= quiet_next;
		end
	end
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	a_reset_ready_high: assert property ($rose(rst_n_in) |->
		result_ready_n_out) else $error("ready low after reset");
	a_update_span: assert property (conv_valid_in &&
		!result_ready_n_out |=> result_ready_n_out ##19
		result_ready_n_out ##1 !result_ready_n_out)
		else $error("update window length wrong");
	a_stat_mirror: assert property (reg_rd_in &&
		reg_addr_in == ADDR_STAT |=> reg_rdata_out[STAT_CRM_BIT] ||
		reg_rdata_out[STAT_READY_BIT] == $past(result_ready_n_out))
		else $error("status ready bit differs from pin");
	a_rdata_idle: assert property (!reg_rd_in |=>
		reg_rdata_out == 8'h00) else $error("read data without read");
	a_unmapped_zero: assert property (reg_rd_in &&
		reg_addr_in[1] |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_ctrl_readback: assert property (reg_wr_in &&
		reg_addr_in == ADDR_CTRL ##1 reg_rd_in &&
		reg_addr_in == ADDR_CTRL |=>
		reg_rdata_out == ($past(reg_wdata_in, 2) & 8'h07))
		else $error("control readback wrong");
	a_oe_tracks_cs: assert property (cs_n_in [*4] |->
		dout_oe_n_out) else $error("output enabled while deselected");
	a_rise_cause: assert property ($rose(result_ready_n_out) |->
		$past(conv_valid_in) || $past(conv_start_in) ||
		quiet_reg < 4'h8) else $error("ready rose without cause");
	c_window: cover property (conv_valid_in && !result_ready_n_out);
	c_stat_read: cover property (reg_rd_in && reg_addr_in == ADDR_STAT);
	c_read_clear: cover property ($rose(result_ready_n_out) &&
		quiet_reg < 4'h8);
endmodule : arr_readout_assertions

bind arr_readout arr_readout_assertions arr_readout_assertions_inst (
	.clk_sys_in, .rst_n_in, .conv_valid_in, .conv_start_in,
	.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
	.reg_rdata_out, .sclk_in, .cs_n_in, .dout_oe_n_out,
	.result_ready_n_out);

// [test/arr_host_model.sv]
/* Host serial controller model: selects, clocks and shifts.
 Assumes the bench calls sel and xfer and reads rx and rdy1. */
`timescale 1ns/1ns
module arr_host_model (
	// Serial pins
	input  wire logic dout_in,
	input  wire logic ready_n_in,
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      din_out
);
	logic [63:0] rx;
	logic        rdy1;
	// clock idles low, data input low
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		din_out = 1'b0;
		rx = 64'h0;
		rdy1 = 1'b1;
	end
	task automatic sel(input logic v);
		cs_n_out <= v;
		#100;
	endtask : sel
	task automatic xfer(input int n, input logic [63:0] tx);
		rx = 64'h0;
		for (int i = 0; i < n; i++) begin
			din_out <= tx[n - 1 - i];
			#40 sclk_out <= 1'b1;
			#80 rx = {rx[62:0], dout_in};
			if (i == 0)
				rdy1 = ready_n_in;
			sclk_out <= 1'b0;
			#40;
		end
		din_out <= 1'b0;
	endtask : xfer
endmodule : arr_host_model

// [test/arr_readout_tb.sv]
/* Bench for arr_readout with a host serial model.
 Assumes arr_pkg, the checker and the host model compile first. */
`timescale 1ns/1ns
module arr_readout_tb import arr_pkg::*;;
	logic        clk_sys_in, rst_n_in, conv_valid_in, conv_oor_in;
	logic        conv_start_in, reg_wr_in, reg_rd_in, sclk_in;
	logic        cs_n_in, din_in, dout_out, dout_oe_n_out, dout_w;
	logic        result_ready_n_out;
	logic [25:0] conv_raw_in;
	logic [1:0]  reg_addr_in;
	logic [7:0]  reg_wdata_in, reg_rdata_out;
	int          n_errors, n_checks;
	// Released line shows the inverse so a stale bit never matches
	assign dout_w = dout_oe_n_out ? ~dout_out : dout_out;
	arr_readout arr_readout_inst (.clk_sys_in, .rst_n_in,
		.conv_valid_in, .conv_raw_in, .conv_oor_in, .conv_start_in,
		.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
		.reg_rdata_out, .sclk_in, .cs_n_in, .din_in, .dout_out,
		.dout_oe_n_out, .result_ready_n_out);
	arr_host_model arr_host_model_inst (.dout_in(dout_w),
		.ready_n_in(result_ready_n_out), .sclk_out(sclk_in),
		.cs_n_out(cs_n_in), .din_out(din_in));
	always #5 clk_sys_in = ~clk_sys_in;
	// ****
	// Shared tasks
	// ****
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	task automatic acc(input logic w, r, input logic [1:0] a,
		input logic [7:0] d);
		@(posedge clk_sys_in);
		reg_wr_in <= w;
		reg_rd_in <= r;
		reg_addr_in <= a;
		reg_wdata_in <= d;
	endtask : acc
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		acc(1'b0, 1'b1, a, 8'h00);
		acc(1'b0, 1'b0, a, 8'h00);
		#1 chk(reg_rdata_out, e);
	endtask : rd
	task automatic setc(input logic [2:0] c);
		acc(1'b1, 1'b0, ADDR_CTRL, {5'h00, c});
		rd(ADDR_CTRL, {5'h00, c}); // control readback
	endtask : setc
	task automatic conv(input logic [25:0] raw, input logic f,
		output int k);
		@(posedge clk_sys_in);
		conv_valid_in <= 1'b1;
		conv_raw_in <= raw;
		conv_oor_in <= f;
		@(posedge clk_sys_in);
		conv_valid_in <= 1'b0;
		#1 k = 0;
		while (result_ready_n_out === 1'b1 && k < 60) begin
			@(posedge clk_sys_in);
			#1 k++;
		end
		if (k == 60) begin
			n_errors++;
			complete_run();
		end
	endtask : conv
	function automatic logic [63:0] fmt(logic [23:0] d, logic f,
		logic [2:0] c);
		logic [7:0] s;
		s = d[23:16] + d[15:8] + d[7:0] + SUM_OFFSET;
		if (c[CTRL_FLAG_BIT] && c[CTRL_SUM_BIT])
			s[7] = f;
		if (c[CTRL_FLAG_BIT] && !c[CTRL_SUM_BIT])
			d[0] = f;
		return c[CTRL_SUM_BIT] ? {d, s, d, s} : {16'h0000, d, d};
	endfunction : fmt
	// ****
	// Scenarios
	// ****
	task automatic t_reset;
		chk(result_ready_n_out, 1'b1); // ready high
		chk(dout_oe_n_out, 1'b1); // released
		rd(ADDR_STAT, 8'h03); // continuous at reset
		rd(ADDR_CTRL, {5'h00, CTRL_RESET}); // control default
		acc(1'b1, 1'b0, 2'h3, 8'hff);
		rd(2'h3, 8'h00); // unmapped reads zero
		arr_host_model_inst.sel(1'b0);
		chk(dout_oe_n_out, 1'b0); // driven when selected
		$display("t_reset done");
	endtask : t_reset
	task automatic t_formats;
		logic [25:0] raw[4] = '{26'h0123456, 26'h0800000,
			26'h3000000, 26'h00000aa};
		logic [23:0] dat[4] = '{24'h123456, 24'h7fffff, 24'h800000,
			24'h0000aa};
		logic [2:0]  cfg[4] = '{3'h0, 3'h1, 3'h3, 3'h2};
		logic [3:0]  oor = 4'b1100;
		logic [63:0] want;
		int          k;
		for (int i = 0; i < 4; i++) begin
			setc(cfg[i]);
			conv(raw[i], oor[i], k);
			chk(k, UPDATE_CYC); // window length
			#20 chk(dout_w, 1'b0); // output low with ready
			arr_host_model_inst.xfer(cfg[i][0] ? 64 : 48, 64'h0);
			chk(arr_host_model_inst.rdy1, 1'b0); // not on rise
			chk(result_ready_n_out, 1'b1); // cleared by fall
			want = fmt(dat[i], oor[i], cfg[i]);
			chk(arr_host_model_inst.rx, want);
		end
		$display("t_formats done");
	endtask : t_formats
	task automatic t_unread;
		int k;
		setc(3'h0);
		conv(26'h0000111, 1'b0, k);
		conv(26'h3fffffe, 1'b0, k);
		chk(k, UPDATE_CYC); // pulse high when unread
		arr_host_model_inst.xfer(24, 64'h0);
		chk(arr_host_model_inst.rx, 64'hfffffe); // newest word
		$display("t_unread done");
	endtask : t_unread
	task automatic t_pulse;
		int k;
		setc(3'h4);
		conv(26'h0000022, 1'b0, k);
		arr_host_model_inst.xfer(24, 64'h0);
		chk(result_ready_n_out, 1'b0); // stays low after read
		@(posedge clk_sys_in);
		conv_start_in <= 1'b1;
		@(posedge clk_sys_in);
		conv_start_in <= 1'b0;
		// Settled value, one step after the edge that takes the start
		#1 chk(result_ready_n_out, 1'b1); // start raises ready
		$display("t_pulse done");
	endtask : t_pulse
	task automatic t_stop;
		int k;
		setc(3'h0);
		conv(26'h0000033, 1'b0, k);
		arr_host_model_inst.xfer(8, {56'h0, CMD_STOP_CRM});
		conv(26'h0000044, 1'b0, k);
		rd(ADDR_STAT, 8'h00); // mirror outside continuous
		setc(3'h1);
		arr_host_model_inst.xfer(8, {56'h0, CMD_RDATA_HI, 1'b0});
		arr_host_model_inst.xfer(64, 64'h0);
		chk(arr_host_model_inst.rx, fmt(24'h44, 1'b0, 3'h1));
		chk(result_ready_n_out, 1'b1); // cleared by command read
		arr_host_model_inst.xfer(8, {56'h0, CMD_START_CRM});
		rd(ADDR_STAT, 8'h03); // continuous again
		$display("t_stop done");
	endtask : t_stop
	initial begin
		clk_sys_in = 1'b0;
		rst_n_in = 1'b0;
		{conv_valid_in, conv_oor_in, conv_start_in} = 3'h0;
		{reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = 12'h000;
		conv_raw_in = 26'h0000000;
		n_errors = 0;
		n_checks = 0;
		repeat (12) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		t_reset();
		t_formats();
		t_unread();
		t_pulse();
		t_stop();
		complete_run();
	end
endmodule : arr_readout_tb
